// >>> design/rtc_core.sv
// Real-time clock core with calendar, alarms, periodic events and DST shifts
`timescale 1ns/1ps

module rtc_core #(
	parameter int SEC_CYC = rtc_pkg::SEC_CYC,
	parameter int UIP_CYC = rtc_pkg::UIP_CYC
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SRST,
	// Host I/O window
	input wire logic [15:0] HOST_BASE,
	input wire logic [15:0] HOST_ADDR,
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	input wire logic [7:0] HOST_WDATA,
	output logic [7:0] HOST_RDATA,
	output logic HOST_ACK,
	// Controller bus
	input wire logic [31:0] EC_ADDR,
	input wire logic EC_WR,
	input wire logic EC_RD,
	input wire logic [31:0] EC_WDATA,
	output logic [31:0] EC_RDATA,
	output logic EC_ACK,
	// Interrupts
	output logic HOST_IRQ,
	output logic EC_IRQ,
	output logic ALARM_WAKE
);

	// All state lives in one struct; the comb block builds its next value
	rtc_pkg::rtc_state_s st_ff, nxt_st;

	// Hit flag and offset together; addresses below the base wrap high and miss
	function automatic logic [6:0] win_hit(input logic [31:0] addr, input logic [31:0] base);
		logic [31:0] diff;
		diff = addr - base;
		win_hit = {diff < rtc_pkg::WIN_SIZE, diff[5:0]};
	endfunction

	// The calendar always steps in binary and converts at the register boundary
	function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
		to_bin = bin ? v : ({4'h0, v[7:4]} * 8'd10) + {4'h0, v[3:0]};
	endfunction

	function automatic logic [7:0] to_fmt(input logic [7:0] v, input logic bin);
		to_fmt = bin ? v : {4'(v / 8'd10), 4'(v % 8'd10)};
	endfunction

	// Hours register to 0-23 and back, covering 12-hour mode
	function automatic logic [7:0] hour_get(input logic [7:0] v, input logic [7:0] fmt);
		logic [7:0] h;
		h = to_bin({1'b0, v[6:0]}, fmt[rtc_pkg::FMT_BIN]);
		if (fmt[rtc_pkg::FMT_H24]) begin
			hour_get = h;
		end else begin
			hour_get = ((h == 8'd12) ? 8'd0 : h) + (v[7] ? 8'd12 : 8'd0);
		end
	endfunction

	// Back to the stored form; in 12-hour mode bit 7 marks the afternoon
	function automatic logic [7:0] hour_put(input logic [7:0] h, input logic [7:0] fmt);
		logic [7:0] h12;
		logic [7:0] f12;
		h12 = (h % 8'd12 == 8'd0) ? 8'd12 : h % 8'd12;
		f12 = to_fmt(h12, fmt[rtc_pkg::FMT_BIN]);
		if (fmt[rtc_pkg::FMT_H24]) begin
			hour_put = to_fmt(h, fmt[rtc_pkg::FMT_BIN]);
		end else begin
			hour_put = {h >= 8'd12, f12[6:0]};
		end
	endfunction

	// Leap rule covers years divisible by four only, enough for a two-digit year
	function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] year);
		unique case (mon)
			8'd4, 8'd6, 8'd9, 8'd11: month_days = 8'd30;
			8'd2: month_days = (year[1:0] == 2'h0) ? 8'd29 : 8'd28;
			default: month_days = 8'd31;
		endcase
	endfunction

	// Compared in stored format, so match values must use the current format
	function automatic logic field_match(input logic [7:0] m, input logic [7:0] v);
		field_match = (m[7:6] == rtc_pkg::WILD) || (m == v);
	endfunction

	// Unmapped offsets read zero; nothing is stored behind the old RAM offsets
	function automatic logic [31:0] reg_read(input rtc_pkg::rtc_state_s t, input logic [5:0] off,
			input logic uip);
		reg_read = 32'h0;
		unique case (off)
			rtc_pkg::OFF_SEC: reg_read[7:0] = t.sec;
			rtc_pkg::OFF_SEC_M: reg_read[7:0] = t.sec_m;
			rtc_pkg::OFF_MIN: reg_read[7:0] = t.min;
			rtc_pkg::OFF_MIN_M: reg_read[7:0] = t.min_m;
			rtc_pkg::OFF_HOUR: reg_read[7:0] = t.hour;
			rtc_pkg::OFF_HOUR_M: reg_read[7:0] = t.hour_m;
			rtc_pkg::OFF_WDAY: reg_read[7:0] = t.wday;
			rtc_pkg::OFF_MDAY: reg_read[7:0] = t.mday;
			rtc_pkg::OFF_MON: reg_read[7:0] = t.mon;
			rtc_pkg::OFF_YEAR: reg_read[7:0] = t.year;
			rtc_pkg::OFF_RATE: reg_read[7:0] = {uip, t.rate[6:0]};
			rtc_pkg::OFF_FMT: reg_read[7:0] = t.fmt;
			rtc_pkg::OFF_FLAGS: reg_read[7:0] = {t.host_irq, t.pf, t.af, t.uf, 4'h0};
			rtc_pkg::OFF_DATE_M: reg_read[7:0] = rtc_pkg::DATE_VALID | {2'h0, t.date_m};
			rtc_pkg::OFF_CTRL: reg_read[1:0] = {t.soft_rst, t.ctrl_en};
			rtc_pkg::OFF_WEEK_M: reg_read[7:0] = t.week_m;
			rtc_pkg::OFF_DST_F: reg_read = t.dst_f;
			rtc_pkg::OFF_DST_B: reg_read = t.dst_b;
			default: reg_read = 32'h0;
		endcase
	endfunction

	// Stores raw; callers encode time in the current format
	function automatic rtc_pkg::rtc_state_s reg_write(input rtc_pkg::rtc_state_s t,
			input logic [5:0] off, input logic [31:0] d);
		reg_write = t;
		unique case (off)
			rtc_pkg::OFF_SEC: reg_write.sec = d[7:0];
			rtc_pkg::OFF_SEC_M: reg_write.sec_m = d[7:0];
			rtc_pkg::OFF_MIN: reg_write.min = d[7:0];
			rtc_pkg::OFF_MIN_M: reg_write.min_m = d[7:0];
			rtc_pkg::OFF_HOUR: reg_write.hour = d[7:0];
			rtc_pkg::OFF_HOUR_M: reg_write.hour_m = d[7:0];
			rtc_pkg::OFF_WDAY: reg_write.wday = d[7:0];
			rtc_pkg::OFF_MDAY: reg_write.mday = d[7:0];
			rtc_pkg::OFF_MON: reg_write.mon = d[7:0];
			rtc_pkg::OFF_YEAR: reg_write.year = d[7:0];
			rtc_pkg::OFF_RATE: reg_write.rate = {1'b0, d[6:0]};
			rtc_pkg::OFF_FMT: reg_write.fmt = d[7:0];
			rtc_pkg::OFF_DATE_M: reg_write.date_m = d[5:0];
			rtc_pkg::OFF_CTRL: begin
				reg_write.ctrl_en = d[rtc_pkg::CTRL_EN];
				reg_write.soft_rst = d[rtc_pkg::CTRL_SRST];
			end
			rtc_pkg::OFF_WEEK_M: reg_write.week_m = d[7:0];
			rtc_pkg::OFF_DST_F: reg_write.dst_f = d;
			rtc_pkg::OFF_DST_B: reg_write.dst_b = d;
			default: reg_write = t;
		endcase
	endfunction

	// DST setup word: [7:0] month, [15:8] day, [23:16] hour, all binary
	function automatic logic dst_hit(input logic [31:0] cfg, input logic [7:0] mo,
			input logic [7:0] md, input logic [7:0] h);
		dst_hit = cfg[rtc_pkg::DST_EN] && cfg[7:0] == mo && cfg[15:8] == md && cfg[23:16] == h;
	endfunction

	// Working values of the comb block, each set on every path
	logic [6:0] host_win, ec_win;
	logic [31:0] byte_word;
	logic ec_ctrl_wr, host_ctrl_wr;
	logic host_hit, ec_hit, run, sec_tick, base_tick, uip;
	logic evt_p, evt_a, evt_u, clr_flags, bin;
	logic [7:0] b_sec, b_min, b_hour, b_wday, b_mday, b_mon, b_year;
	logic [15:0] per_len;
	logic [31:0] host_word;
	logic [5:0] host_off;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.host_ack = 1'b0;
		nxt_st.ec_ack = 1'b0;
		nxt_st.upd = 1'b0;
		host_win = win_hit({16'h0, HOST_ADDR}, {16'h0, HOST_BASE});
		ec_win = win_hit(EC_ADDR, rtc_pkg::EC_BASE);
		host_hit = host_win[6];
		ec_hit = ec_win[6];
		host_off = host_win[5:0];
		bin = st_ff.fmt[rtc_pkg::FMT_BIN];
		run = st_ff.ctrl_en && st_ff.rate[6:4] == rtc_pkg::DIV_RUN;
		evt_p = 1'b0;
		evt_a = 1'b0;
		evt_u = 1'b0;
		sec_tick = 1'b0;
		base_tick = 1'b0;
		b_sec = to_bin(st_ff.sec, bin);
		b_min = to_bin(st_ff.min, bin);
		b_hour = hour_get(st_ff.hour, st_ff.fmt);
		b_wday = st_ff.wday;
		b_mday = to_bin(st_ff.mday, bin);
		b_mon = to_bin(st_ff.mon, bin);
		b_year = to_bin(st_ff.year, bin);
		// Periodic divider: one base tick, then 2^(rate-1) of them per event
		per_len = 16'h1 << (st_ff.rate[3:0] - 4'h1);
		uip = run && st_ff.presc >= 27'(SEC_CYC - UIP_CYC);
		// Second prescaler, held in reset while the divider is stopped
		if (!run) begin
			nxt_st.presc = 27'h0;
			nxt_st.per_presc = 12'h0;
			nxt_st.per_cnt = 16'h0;
		end else begin
			sec_tick = st_ff.presc == 27'(SEC_CYC - 1);
			nxt_st.presc = sec_tick ? 27'h0 : st_ff.presc + 27'h1;
			base_tick = st_ff.per_presc == rtc_pkg::PER_CYC - 12'h1;
			nxt_st.per_presc = base_tick ? 12'h0 : st_ff.per_presc + 12'h1;
			if (base_tick && st_ff.rate[3:0] != 4'h0) begin
				if (st_ff.per_cnt + 16'h1 >= per_len) begin
					evt_p = 1'b1;
					nxt_st.per_cnt = 16'h0;
				end else begin
					nxt_st.per_cnt = st_ff.per_cnt + 16'h1;
				end
			end
		end

		// Calendar step; holding the halt bit freezes it for safe setting
		if (sec_tick && !st_ff.fmt[rtc_pkg::FMT_HALT]) begin
			nxt_st.upd = 1'b1;
			b_sec = b_sec + 8'h1;
			if (b_sec >= 8'd60) begin
				b_sec = 8'h0;
				b_min = b_min + 8'h1;
			end
			if (b_min >= 8'd60) begin
				b_min = 8'h0;
				b_hour = b_hour + 8'h1;
			end
			if (b_hour >= 8'd24) begin
				b_hour = 8'h0;
				// Weekday runs 1 to 7 and reads the same in both formats
				b_wday = (b_wday >= 8'd7) ? 8'd1 : b_wday + 8'h1;
				b_mday = b_mday + 8'h1;
				nxt_st.bwd_done = 1'b0;
			end
			if (b_mday > month_days(b_mon, b_year)) begin
				b_mday = 8'd1;
				b_mon = b_mon + 8'h1;
			end
			if (b_mon > 8'd12) begin
				b_mon = 8'd1;
				b_year = (b_year >= 8'd99) ? 8'h0 : b_year + 8'h1;
			end
			// Backward shift is latched once per day so the repeated hour is not shifted again
			if (st_ff.fmt[rtc_pkg::FMT_DSE] && b_min == 8'h0 && b_sec == 8'h0) begin
				if (dst_hit(st_ff.dst_f, b_mon, b_mday, b_hour) && b_hour < 8'd23) begin
					b_hour = b_hour + 8'h1;
				end else if (dst_hit(st_ff.dst_b, b_mon, b_mday, b_hour) && !st_ff.bwd_done
						&& b_hour != 8'h0) begin
					b_hour = b_hour - 8'h1;
					nxt_st.bwd_done = 1'b1;
				end
			end
			nxt_st.sec = to_fmt(b_sec, bin);
			nxt_st.min = to_fmt(b_min, bin);
			nxt_st.hour = hour_put(b_hour, st_ff.fmt);
			nxt_st.wday = b_wday;
			nxt_st.mday = to_fmt(b_mday, bin);
			nxt_st.mon = to_fmt(b_mon, bin);
			nxt_st.year = to_fmt(b_year, bin);
		end

		// Events are judged the cycle after the update, on settled counts
		if (st_ff.upd) begin
			evt_u = 1'b1;
			evt_a = field_match(st_ff.sec_m, st_ff.sec)
				&& field_match(st_ff.min_m, st_ff.min)
				&& field_match(st_ff.hour_m, st_ff.hour)
				&& (st_ff.date_m == 6'h0 || st_ff.date_m == st_ff.mday[5:0])
				&& field_match(st_ff.week_m, st_ff.wday);
		end

		// Host port: byte access; from OFF_CTRL up the lane is picked from the low offset bits
		clr_flags = 1'b0;
		host_word = reg_read(st_ff, {host_off[5:2], 2'h0}, uip);
		byte_word = reg_read(st_ff, host_off, uip);
		if (host_hit && HOST_RD) begin
			nxt_st.host_ack = 1'b1;
			if (host_off < rtc_pkg::OFF_CTRL) begin
				nxt_st.host_rdata = byte_word[7:0];
			end else begin
				nxt_st.host_rdata = host_word[8 * host_off[1:0] +: 8];
			end
			clr_flags = host_off == rtc_pkg::OFF_FLAGS;
		end
		if (host_hit && HOST_WR) begin
			nxt_st.host_ack = 1'b1;
			if (host_off < rtc_pkg::OFF_CTRL) begin
				nxt_st = reg_write(nxt_st, host_off, {24'h0, HOST_WDATA});
			end else begin
				host_word[8 * host_off[1:0] +: 8] = HOST_WDATA;
				nxt_st = reg_write(nxt_st, {host_off[5:2], 2'h0}, host_word);
			end
		end
		// Controller port: word access; it wins any same-cycle conflict
		if (ec_hit && EC_RD) begin
			nxt_st.ec_ack = 1'b1;
			nxt_st.ec_rdata = reg_read(st_ff, ec_win[5:0], uip);
			clr_flags = clr_flags || ec_win[5:0] == rtc_pkg::OFF_FLAGS;
		end
		if (ec_hit && EC_WR) begin
			nxt_st.ec_ack = 1'b1;
			nxt_st = reg_write(nxt_st, ec_win[5:0], EC_WDATA);
		end
		// Read clears the flags; a new event in the same cycle survives
		// HOST_IRQ and EC_IRQ are levels that follow the enabled flags; wake pulses on each alarm, ungated
		nxt_st.pf = (st_ff.pf && !clr_flags) || evt_p;
		nxt_st.af = (st_ff.af && !clr_flags) || evt_a;
		nxt_st.uf = (st_ff.uf && !clr_flags) || evt_u;
		nxt_st.host_irq = (nxt_st.pf && nxt_st.fmt[rtc_pkg::FMT_PIE])
			|| (nxt_st.af && nxt_st.fmt[rtc_pkg::FMT_AIE])
			|| (nxt_st.uf && nxt_st.fmt[rtc_pkg::FMT_UIE]);
		nxt_st.ec_irq = nxt_st.host_irq;
		nxt_st.wake = evt_a;

		// Soft reset holds the rest in reset; only the control word stays writable
		ec_ctrl_wr = ec_hit && EC_WR && ec_win[5:0] == rtc_pkg::OFF_CTRL;
		host_ctrl_wr = host_hit && HOST_WR && host_off == rtc_pkg::OFF_CTRL;
		if (st_ff.soft_rst) begin
			nxt_st = '0;
			nxt_st.rate = rtc_pkg::RST_RATE;
			nxt_st.fmt = rtc_pkg::RST_FMT;
			nxt_st.soft_rst = 1'b1;
			nxt_st.host_ack = host_hit && (HOST_RD || HOST_WR);
			nxt_st.ec_ack = ec_hit && (EC_RD || EC_WR);
			if (ec_ctrl_wr) begin
				nxt_st.soft_rst = EC_WDATA[rtc_pkg::CTRL_SRST];
				nxt_st.ctrl_en = EC_WDATA[rtc_pkg::CTRL_EN];
			end else if (host_ctrl_wr) begin
				nxt_st.soft_rst = HOST_WDATA[rtc_pkg::CTRL_SRST];
				nxt_st.ctrl_en = HOST_WDATA[rtc_pkg::CTRL_EN];
			end
		end
	end

	// Single clock for everything; no low-power gating
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			st_ff <= '0;
			st_ff.rate <= rtc_pkg::RST_RATE;
			st_ff.fmt <= rtc_pkg::RST_FMT;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// No RAM behind unused offsets and no square-wave pin
	assign HOST_RDATA = st_ff.host_rdata;
	assign HOST_ACK = st_ff.host_ack;
	assign EC_RDATA = st_ff.ec_rdata;
	assign EC_ACK = st_ff.ec_ack;
	assign HOST_IRQ = st_ff.host_irq;
	assign EC_IRQ = st_ff.ec_irq;
	assign ALARM_WAKE = st_ff.wake;

endmodule

// >>> design/rtc_pkg.sv
// Constants, offsets and state layout of the real-time clock core
package rtc_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam longint SEC_NS = 1000000000;
	localparam int SEC_CYC = int'(SEC_NS / CLK_PERIOD_NS);
	localparam int UIP_NS = 244000;
	localparam int UIP_CYC = UIP_NS / CLK_PERIOD_NS;
	localparam int PER_BASE_NS = 30517;
	localparam logic [11:0] PER_CYC = 12'(PER_BASE_NS / CLK_PERIOD_NS);
	// Bases
	localparam logic [31:0] EC_BASE = 32'h400f2c00;
	localparam logic [31:0] WIN_SIZE = 32'h00000024;
	// Register offsets
	localparam logic [5:0] OFF_SEC = 6'h00;
	localparam logic [5:0] OFF_SEC_M = 6'h01;
	localparam logic [5:0] OFF_MIN = 6'h02;
	localparam logic [5:0] OFF_MIN_M = 6'h03;
	localparam logic [5:0] OFF_HOUR = 6'h04;
	localparam logic [5:0] OFF_HOUR_M = 6'h05;
	localparam logic [5:0] OFF_WDAY = 6'h06;
	localparam logic [5:0] OFF_MDAY = 6'h07;
	localparam logic [5:0] OFF_MON = 6'h08;
	localparam logic [5:0] OFF_YEAR = 6'h09;
	localparam logic [5:0] OFF_RATE = 6'h0a;
	localparam logic [5:0] OFF_FMT = 6'h0b;
	localparam logic [5:0] OFF_FLAGS = 6'h0c;
	localparam logic [5:0] OFF_DATE_M = 6'h0d;
	localparam logic [5:0] OFF_CTRL = 6'h10;
	localparam logic [5:0] OFF_WEEK_M = 6'h14;
	localparam logic [5:0] OFF_DST_F = 6'h18;
	localparam logic [5:0] OFF_DST_B = 6'h1c;
	// Field positions
	localparam int FMT_HALT = 7;
	localparam int FMT_PIE = 6;
	localparam int FMT_AIE = 5;
	localparam int FMT_UIE = 4;
	localparam int FMT_BIN = 2;
	localparam int FMT_H24 = 1;
	localparam int FMT_DSE = 0;
	localparam int CTRL_EN = 0;
	localparam int CTRL_SRST = 1;
	localparam int DST_EN = 31;
	localparam logic [2:0] DIV_RUN = 3'h2;
	localparam logic [1:0] WILD = 2'h3;
	localparam logic [7:0] DATE_VALID = 8'h80;
	// Reset values
	localparam logic [7:0] RST_RATE = 8'h26;
	localparam logic [7:0] RST_FMT = 8'h02;
	// Whole state of the core
	typedef struct packed {
		logic [7:0] sec, sec_m, min, min_m, hour, hour_m, wday, mday, mon, year;
		logic [7:0] rate, fmt, week_m;
		logic [5:0] date_m;
		logic pf, af, uf;
		logic ctrl_en, soft_rst, bwd_done, upd;
		logic [31:0] dst_f, dst_b;
		logic [26:0] presc;
		logic [11:0] per_presc;
		logic [15:0] per_cnt;
		logic [7:0] host_rdata;
		logic host_ack;
		logic [31:0] ec_rdata;
		logic ec_ack, host_irq, ec_irq, wake;
	} rtc_state_s;
endpackage

// >>> test/rtc_bus_model.sv
// Host and controller bus masters facing the clock core
`timescale 1ns/1ps
module rtc_bus_model (
	// Clock
	input wire logic MCLK,
	// Host window
	output logic [15:0] HOST_BASE,
	output logic [15:0] HOST_ADDR,
	output logic HOST_WR,
	output logic HOST_RD,
	output logic [7:0] HOST_WDATA,
	input wire logic [7:0] HOST_RDATA,
	input wire logic HOST_ACK,
	// Controller bus
	output logic [31:0] EC_ADDR,
	output logic EC_WR,
	output logic EC_RD,
	output logic [31:0] EC_WDATA,
	input wire logic [31:0] EC_RDATA,
	input wire logic EC_ACK
);
	initial begin
		HOST_BASE = 16'h0070;
		HOST_ADDR = 16'h0000;
		HOST_WDATA = 8'h00;
		EC_ADDR = 32'h00000000;
		EC_WDATA = 32'h00000000;
		{HOST_WR, HOST_RD, EC_WR, EC_RD} = 4'h0;
	end
	// Strobe lasts one cycle; the answer is sampled a cycle later
	task automatic host_acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ack);
		@(negedge MCLK);
		HOST_ADDR = a;
		HOST_WDATA = d;
		{HOST_WR, HOST_RD} = {wr, !wr};
		@(negedge MCLK);
		ack = HOST_ACK;
		q = HOST_RDATA;
		{HOST_WR, HOST_RD} = 2'h0;
		// Released lines show garbage, not the old value
		HOST_ADDR = ~a;
		HOST_WDATA = ~d;
	endtask
	task automatic ec_acc(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic ack);
		@(negedge MCLK);
		EC_ADDR = a;
		EC_WDATA = d;
		{EC_WR, EC_RD} = {wr, !wr};
		@(negedge MCLK);
		ack = EC_ACK;
		q = EC_RDATA;
		{EC_WR, EC_RD} = 2'h0;
		EC_ADDR = ~a;
		EC_WDATA = ~d;
	endtask
endmodule

// >>> test/rtc_core_asserts.sv
// Port-level checks for the clock core
`timescale 1ns/1ps
module rtc_core_asserts #(
	parameter int SEC_CYC = rtc_pkg::SEC_CYC,
	parameter int UIP_CYC = rtc_pkg::UIP_CYC
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SRST,
	// Host window
	input wire logic [15:0] HOST_BASE,
	input wire logic [15:0] HOST_ADDR,
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	input wire logic [7:0] HOST_RDATA,
	input wire logic HOST_ACK,
	// Controller bus
	input wire logic [31:0] EC_ADDR,
	input wire logic EC_WR,
	input wire logic EC_RD,
	input wire logic [31:0] EC_RDATA,
	input wire logic EC_ACK,
	// Interrupts
	input wire logic HOST_IRQ,
	input wire logic EC_IRQ,
	input wire logic ALARM_WAKE
);
	wire logic host_req = (HOST_RD || HOST_WR) && (16'(HOST_ADDR - HOST_BASE) < 16'h0024);
	wire logic ec_req = (EC_RD || EC_WR) && ((EC_ADDR - rtc_pkg::EC_BASE) < rtc_pkg::WIN_SIZE);
	wire logic any_acc = HOST_RD || HOST_WR || EC_RD || EC_WR;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);
	property p_host_ack; host_req |=> HOST_ACK; endproperty
	a_host_ack: assert property (p_host_ack) else $error("host access not answered");
	property p_host_only; HOST_ACK |-> $past(host_req); endproperty
	a_host_only: assert property (p_host_only) else $error("host answer without access");
	property p_ec_ack; ec_req |=> EC_ACK; endproperty
	a_ec_ack: assert property (p_ec_ack) else $error("controller access not answered");
	property p_ec_only; EC_ACK |-> $past(ec_req); endproperty
	a_ec_only: assert property (p_ec_only) else $error("controller answer without access");
	property p_host_hold; !(host_req && HOST_RD) |=> $stable(HOST_RDATA); endproperty
	a_host_hold: assert property (p_host_hold) else $error("host read data moved");
	property p_irq_same; HOST_IRQ == EC_IRQ; endproperty
	a_irq_same: assert property (p_irq_same) else $error("interrupt outputs differ");
	property p_wake; $rose(ALARM_WAKE) |=> !ALARM_WAKE [*8]; endproperty
	a_wake: assert property (p_wake) else $error("wake pulse too long");
	property p_rst; $fell(SRST) |-> !(HOST_IRQ || EC_IRQ || ALARM_WAKE || HOST_ACK || EC_ACK); endproperty
	a_rst: assert property (p_rst) else $error("output active after reset");
	// Interrupts only drop after software touched the registers
	property p_irq_fall; $fell(HOST_IRQ) |-> $past(any_acc) || $past(any_acc, 2) || $past(any_acc, 3); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
endmodule

bind rtc_core rtc_core_asserts #(.SEC_CYC(SEC_CYC), .UIP_CYC(UIP_CYC)) u_chk (
	.MCLK(MCLK), .SRST(SRST), .HOST_BASE(HOST_BASE), .HOST_ADDR(HOST_ADDR),
	.HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_RDATA(HOST_RDATA), .HOST_ACK(HOST_ACK),
	.EC_ADDR(EC_ADDR), .EC_WR(EC_WR), .EC_RD(EC_RD), .EC_RDATA(EC_RDATA), .EC_ACK(EC_ACK),
	.HOST_IRQ(HOST_IRQ), .EC_IRQ(EC_IRQ), .ALARM_WAKE(ALARM_WAKE));

// >>> test/rtc_core_test.sv
// Self-checking bench for the clock core
`timescale 1ns/1ps
module rtc_core_test;
	logic MCLK, SRST, HOST_WR, HOST_RD, HOST_ACK, EC_WR, EC_RD, EC_ACK;
	logic HOST_IRQ, EC_IRQ, ALARM_WAKE;
	logic [15:0] HOST_BASE, HOST_ADDR;
	logic [7:0] HOST_WDATA, HOST_RDATA;
	logic [31:0] EC_ADDR, EC_WDATA, EC_RDATA;
	int err_count = 0;
	int num_checks = 0;
	logic [5:0] holes[4] = '{6'h0e, 6'h0f, 6'h11, 6'h20};
	// Short second keeps the run small
	rtc_core #(.SEC_CYC(50), .UIP_CYC(5)) dut (.MCLK(MCLK), .SRST(SRST),
		.HOST_BASE(HOST_BASE), .HOST_ADDR(HOST_ADDR), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD),
		.HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .HOST_ACK(HOST_ACK),
		.EC_ADDR(EC_ADDR), .EC_WR(EC_WR), .EC_RD(EC_RD), .EC_WDATA(EC_WDATA),
		.EC_RDATA(EC_RDATA), .EC_ACK(EC_ACK), .HOST_IRQ(HOST_IRQ), .EC_IRQ(EC_IRQ),
		.ALARM_WAKE(ALARM_WAKE));
	rtc_bus_model bus (.MCLK(MCLK), .HOST_BASE(HOST_BASE), .HOST_ADDR(HOST_ADDR),
		.HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_WDATA(HOST_WDATA),
		.HOST_RDATA(HOST_RDATA), .HOST_ACK(HOST_ACK), .EC_ADDR(EC_ADDR), .EC_WR(EC_WR),
		.EC_RD(EC_RD), .EC_WDATA(EC_WDATA), .EC_RDATA(EC_RDATA), .EC_ACK(EC_ACK));
	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_bit(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic rd(input logic [5:0] o, output logic [31:0] q);
		logic a;
		bus.ec_acc(1'b0, rtc_pkg::EC_BASE + {26'h0, o}, 32'h0, q, a);
		chk_bit("read ack", 1'b1, a);
	endtask
	task automatic wr(input logic [5:0] o, input logic [31:0] d);
		logic [31:0] q;
		logic a;
		bus.ec_acc(1'b1, rtc_pkg::EC_BASE + {26'h0, o}, d, q, a);
		chk_bit("write ack", 1'b1, a);
	endtask
	task automatic rd_chk(input string n, input logic [5:0] o, input logic [31:0] e);
		logic [31:0] q;
		rd(o, q);
		chk(n, e, q);
	endtask
	// Bounded wait on an output: 0 wake, 1 host irq, 2 controller irq
	task automatic wait_high(input string n, input int sel, input int lim);
		logic s;
		for (int i = 0; i < lim; i++) begin
			@(negedge MCLK);
			s = sel == 0 ? ALARM_WAKE : (sel == 1 ? HOST_IRQ : EC_IRQ);
			if (s === 1'b1)
				break;
		end
		chk_bit(n, 1'b1, s);
		if (s !== 1'b1)
			report_and_stop();
	endtask
	task automatic wait_tick();
		logic [31:0] q;
		for (int i = 0; i < 100; i++) begin
			rd(rtc_pkg::OFF_FLAGS, q);
			if (q[4] === 1'b1)
				return;
		end
		chk_bit("update flag", 1'b1, q[4]);
		report_and_stop();
	endtask
	task automatic s_reset();
		rd_chk("seconds", rtc_pkg::OFF_SEC, 32'h0);
		rd_chk("minutes", rtc_pkg::OFF_MIN, 32'h0);
		rd_chk("sec match", rtc_pkg::OFF_SEC_M, 32'h0);
		rd_chk("min match", rtc_pkg::OFF_MIN_M, 32'h0);
		rd_chk("rate", rtc_pkg::OFF_RATE, {24'h0, rtc_pkg::RST_RATE});
		rd_chk("format", rtc_pkg::OFF_FMT, {24'h0, rtc_pkg::RST_FMT});
		foreach (holes[i]) begin
			wr(holes[i], 32'hffffffff);
			rd_chk("no storage", holes[i], 32'h0);
		end
	endtask
	task automatic s_host();
		logic [7:0] q;
		logic a;
		bus.host_acc(1'b1, 16'h0071, 8'h33, q, a);
		chk_bit("host write ack", 1'b1, a);
		rd_chk("match via ec", rtc_pkg::OFF_SEC_M, 32'h33);
		bus.host_acc(1'b0, 16'h0071, 8'h00, q, a);
		chk("host read", 32'h33, {24'h0, q});
		bus.host_acc(1'b0, 16'h0094, 8'h00, q, a);
		chk_bit("miss ack", 1'b0, a);
	endtask
	task automatic s_count();
		logic [31:0] q;
		logic [7:0] mode;
		wr(rtc_pkg::OFF_CTRL, 32'h1);
		for (int m = 0; m < 2; m++) begin
			mode = m ? 8'h06 : 8'h02;
			wr(rtc_pkg::OFF_FMT, {24'h0, 8'h80 | mode});
			wr(rtc_pkg::OFF_SEC, m ? 32'h3a : 32'h58);
			wr(rtc_pkg::OFF_MIN, 32'h0);
			rd(rtc_pkg::OFF_FLAGS, q);
			wr(rtc_pkg::OFF_FMT, {24'h0, mode});
			wait_tick();
			wait_tick();
			rd_chk("sec wrap", rtc_pkg::OFF_SEC, 32'h0);
			rd_chk("min carry", rtc_pkg::OFF_MIN, 32'h1);
		end
	endtask
	task automatic s_alarm();
		logic [31:0] q;
		int n;
		wr(rtc_pkg::OFF_FMT, 32'h82);
		wr(rtc_pkg::OFF_SEC, 32'h10);
		wr(rtc_pkg::OFF_MIN, 32'h0);
		wr(rtc_pkg::OFF_SEC_M, 32'h12);
		wr(rtc_pkg::OFF_MIN_M, 32'hc0);
		wr(rtc_pkg::OFF_HOUR_M, 32'hc0);
		wr(rtc_pkg::OFF_WEEK_M, 32'hc0);
		wr(rtc_pkg::OFF_DATE_M, 32'h0);
		rd(rtc_pkg::OFF_FLAGS, q);
		wr(rtc_pkg::OFF_FMT, 32'h22);
		wait_high("wake", 0, 300);
		chk_bit("host irq", 1'b1, HOST_IRQ);
		chk_bit("ec irq", 1'b1, EC_IRQ);
		rd_chk("alarm second", rtc_pkg::OFF_SEC, 32'h12);
		rd(rtc_pkg::OFF_FLAGS, q);
		chk("alarm flags", 32'ha0, q & 32'ha0);
		@(negedge MCLK);
		chk_bit("irq cleared", 1'b0, HOST_IRQ);
		wr(rtc_pkg::OFF_MIN_M, 32'h05);
		wr(rtc_pkg::OFF_SEC_M, 32'h13);
		n = 0;
		repeat (120) begin
			@(negedge MCLK);
			n += int'(ALARM_WAKE === 1'b1);
		end
		chk("wake count", 32'h0, n);
	endtask
	task automatic s_irq();
		logic [31:0] q;
		wr(rtc_pkg::OFF_FMT, 32'h42);
		wr(rtc_pkg::OFF_RATE, 32'h21);
		rd(rtc_pkg::OFF_FLAGS, q);
		wait_high("periodic irq", 1, 3300);
		rd(rtc_pkg::OFF_FLAGS, q);
		chk("periodic flag", 32'h40, q & 32'h40);
		wr(rtc_pkg::OFF_RATE, 32'h20);
		wr(rtc_pkg::OFF_FMT, 32'h12);
		rd(rtc_pkg::OFF_FLAGS, q);
		wait_high("update irq", 2, 200);
		rd(rtc_pkg::OFF_FLAGS, q);
		chk("update flag", 32'h10, q & 32'h10);
	endtask
	initial begin
		SRST = 1'b1;
		repeat (20) @(negedge MCLK);
		SRST = 1'b0;
		s_reset();
		s_host();
		s_count();
		s_alarm();
		s_irq();
		report_and_stop();
	end
endmodule
